// [brs_pkg.sv]
// package for the boot, reset and low-power sequencer
// assumes a single system clock domain and an axi4-lite register bus
package brs_pkg;
	// ======================================================================
	// register map (byte addresses)
	localparam logic [7:0] BRS_OFS_OPTION = 8'h00; // option byte, read only
	localparam logic [7:0] BRS_OFS_CTRL   = 8'h04; // low-power control
	localparam logic [7:0] BRS_OFS_STATUS = 8'h08; // sequencer state
	localparam logic [7:0] BRS_OFS_DMAWEN = 8'h0C; // dma wake enables
	localparam logic [7:0] BRS_OFS_BOOT   = 8'h10; // boot result
	// ======================================================================
	// option byte fields
	localparam int BRS_OPT_LPB_HI   = 4;
	localparam int BRS_OPT_LPB_LO   = 0;
	localparam int BRS_OPT_FAST     = 5;
	localparam int BRS_OPT_NMI      = 2;
	localparam int BRS_OPT_BPIN     = 1;
	localparam int BRS_OPT_SRC_HI   = 7;
	localparam int BRS_OPT_SRC_LO   = 6;
	// ======================================================================
	// divider codes and vectors
	localparam logic [3:0] BRS_DIV8 = 4'h7;
	localparam logic [3:0] BRS_DIV4 = 4'h3;
	localparam logic [3:0] BRS_DIV2 = 4'h1;
	localparam logic [3:0] BRS_DIV1 = 4'h0;
	localparam logic [31:0] BRS_VEC_SP  = 32'h0000_0000;
	localparam logic [31:0] BRS_VEC_PC  = 32'h0000_0004;
	localparam logic [31:0] BRS_VEC_NMI = 32'h0000_0008;
	localparam logic [31:0] BRS_LR_RST  = 32'hFFFF_FFFF;
	// ======================================================================
	// timing
	localparam int BRS_CLK_NS       = 10;
	localparam int BRS_CLKEN_NS     = 40;   // clocks settle before flash release
	localparam int BRS_CLKEN_CYC    = (BRS_CLKEN_NS + BRS_CLK_NS - 1) / BRS_CLK_NS;
	localparam int BRS_SLOW_FACTOR  = 4;    // slow flash init clock ratio
	localparam logic [7:0] BRS_CTRL_RST = 8'h00;
	// ======================================================================
	// low power mode selects
	typedef enum logic [1:0] {
		BRS_LP_NONE  = 2'h0,
		BRS_LP_PS1   = 2'h1,
		BRS_LP_PS2   = 2'h2,
		BRS_LP_STOP  = 2'h3
	} brs_lp_e;
	typedef enum logic [11:0] {
		ST_POR     = 12'h001,
		ST_CLKEN   = 12'h002,
		ST_FLASH   = 12'h004,
		ST_PINWAIT = 12'h008,
		ST_RUN     = 12'h010,
		ST_ENT_MST = 12'h020,
		ST_ENT_SLV = 12'h040,
		ST_ENT_PWR = 12'h080,
		ST_LP      = 12'h100,
		ST_DMAWAKE = 12'h200,
		ST_COMPUTE = 12'h400,
		ST_CPDMA   = 12'h800
	} brs_state_e;
	// clock and stop controls to clients
	typedef struct packed {
		logic core_clk_en;
		logic sys_clk_en;
		logic bus_clk_en;
		logic flash_clk_en;
		logic clkgen_en;
		logic regulator_run;
		logic master_stop;
		logic slave_stop;
		logic bus_slave_stop;
	} brs_clk_s;
	// processor boot controls
	typedef struct packed {
		logic        take_nmi;
		logic        force_rom;
		logic [1:0]  boot_src;
		logic [31:0] sp_addr;
		logic [31:0] pc_addr;
		logic [31:0] lr_value;
	} brs_boot_s;
endpackage

// [brs_seq.sv]
// boot, reset exit and low-power sequencer with axi4-lite registers
// assumes inputs from pins and power monitors are asynchronous to clk_sys_in
`timescale 1ns/1ns
module brs_seq import brs_pkg::*; #(
	parameter int DMA_CH      = 4,  // dma channels
	parameter int FLASH_INIT  = 16  // flash init cycles at fast rate
) (
	input  wire logic              clk_sys_in,        // system clock
	input  wire logic              rst_n_in,          // async reset, low
	input  wire logic              supply_good_in,    // supply above por threshold
	input  wire logic              lvd_safe_in,       // detector: regulated supply safe
	input  wire logic [7:0]        nv_option_in,      // nonvolatile option byte
	input  wire logic              reset_pin_in,      // reset pin level
	output logic                   reset_pin_out,     // reset pin drive value
	output logic                   reset_pin_oe_out,  // reset pin drive enable
	input  wire logic              boot_config_pin_in,// boot config / nmi pin
	output logic                   flash_rst_n_out,   // flash controller reset, low
	output logic                   sys_rst_n_out,     // system reset, low
	output logic [3:0]             core_clock_divider_out, // divider code
	output logic                   very_low_power_run_mode_out, // low-power run
	output logic                   flash_slow_clk_out,// flash init slow clock
	output brs_clk_s               clk_ctl_out,       // clock and stop controls
	output brs_boot_s              boot_out,          // boot decisions
	input  wire logic              async_irq_in,      // async module interrupt
	input  wire logic              bus_sync_irq_in,   // bus slave sync interrupt
	input  wire logic [DMA_CH-1:0] dma_req_in,        // dma requests
	input  wire logic              dma_done_in,       // current transfer complete
	input  wire logic              lp_request_in,     // cpu asks for low power
	input  wire logic              compute_req_in,    // compute operation request
	input  wire logic              master_ack_in,     // masters stopped
	input  wire logic              slave_ack_in,      // slaves stopped
	output logic                   stop_abort_out,    // stop abort flag
	input  wire logic [7:0]        s_axi_awaddr,      // write address
	input  wire logic              s_axi_awvalid,     // write address valid
	output logic                   s_axi_awready,     // write address ready
	input  wire logic [31:0]       s_axi_wdata,       // write data
	input  wire logic [3:0]        s_axi_wstrb,       // write strobes
	input  wire logic              s_axi_wvalid,      // write data valid
	output logic                   s_axi_wready,      // write data ready
	output logic [1:0]             s_axi_bresp,       // write response
	output logic                   s_axi_bvalid,      // write response valid
	input  wire logic              s_axi_bready,      // write response ready
	input  wire logic [7:0]        s_axi_araddr,      // read address
	input  wire logic              s_axi_arvalid,     // read address valid
	output logic                   s_axi_arready,     // read address ready
	output logic [31:0]            s_axi_rdata,       // read data
	output logic [1:0]             s_axi_rresp,       // read response
	output logic                   s_axi_rvalid,      // read data valid
	input  wire logic              s_axi_rready       // read data ready
);
	// ======================================================================
	// synchronisers
	logic [1:0] pin_sync_reg;
	logic [1:0] boot_sync_reg;
	logic [1:0] sup_sync_reg;
	logic [1:0] lvd_sync_reg;
	logic [1:0] irq_sync_reg;
	logic [DMA_CH-1:0] dma_s1_reg;
	logic [DMA_CH-1:0] dma_s2_reg;
	// two stage capture of asynchronous levels
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_sync_reg  <= 2'h0;
			boot_sync_reg <= 2'h3;
			sup_sync_reg  <= 2'h0;
			lvd_sync_reg  <= 2'h0;
			irq_sync_reg  <= 2'h0;
			dma_s1_reg    <= '0;
			dma_s2_reg    <= '0;
		end else begin
			pin_sync_reg  <= {pin_sync_reg[0], reset_pin_in};
			boot_sync_reg <= {boot_sync_reg[0], boot_config_pin_in};
			sup_sync_reg  <= {sup_sync_reg[0], supply_good_in};
			lvd_sync_reg  <= {lvd_sync_reg[0], lvd_safe_in};
			irq_sync_reg  <= {irq_sync_reg[0], async_irq_in | bus_sync_irq_in};
			dma_s1_reg    <= dma_req_in;
			dma_s2_reg    <= dma_s1_reg;
		end
	end
	wire pin_high = pin_sync_reg[1];
	wire irq_lvl  = irq_sync_reg[1];
	// ======================================================================
	// registers
	logic [7:0]        option_reg;
	logic [1:0]        lp_mode_reg;
	logic              compute_irq_exit_reg;
	logic [DMA_CH-1:0] dma_wake_en_reg;
	logic              stop_abort_reg;
	brs_state_e        state_reg;
	logic [15:0]       cnt_reg;
	logic              take_nmi_reg;
	logic              force_rom_reg;
	wire  wake_dma = |(dma_s2_reg & dma_wake_en_reg);
	wire  lp_cur   = (lp_mode_reg == BRS_LP_PS1) ? 1'b1 : 1'b0;
	// ======================================================================
	// reset exit and low-power state machine
	wire [15:0] flash_len = option_reg[BRS_OPT_FAST] ? 16'(FLASH_INIT)
		: 16'(FLASH_INIT * BRS_SLOW_FACTOR);
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= ST_POR;
			cnt_reg   <= 16'h0000;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
			case (state_reg)
				ST_POR: begin
					cnt_reg <= 16'h0000;
					if (sup_sync_reg[1] && lvd_sync_reg[1])
						state_reg <= ST_CLKEN;
				end
				ST_CLKEN: if (cnt_reg == 16'(BRS_CLKEN_CYC - 1)) begin
					state_reg <= ST_FLASH;
					cnt_reg   <= 16'h0000;
				end
				ST_FLASH: if (cnt_reg == flash_len - 16'h0001)
					state_reg <= ST_PINWAIT;
				ST_PINWAIT: if (pin_high)
					state_reg <= ST_RUN;
				ST_RUN: begin
					if (compute_req_in)
						state_reg <= ST_COMPUTE;
					else if (lp_request_in && lp_mode_reg != BRS_LP_NONE)
						state_reg <= ST_ENT_MST;
				end
				ST_ENT_MST: begin
					if (irq_lvl)
						state_reg <= ST_RUN;
					else if (wake_dma)
						state_reg <= ST_DMAWAKE;
					else if (master_ack_in)
						state_reg <= ST_ENT_SLV;
				end
				ST_ENT_SLV: begin
					if (irq_lvl)
						state_reg <= ST_RUN;
					else if (wake_dma)
						state_reg <= ST_DMAWAKE;
					else if (slave_ack_in)
						state_reg <= ST_ENT_PWR;
				end
				ST_ENT_PWR: state_reg <= wake_dma ? ST_DMAWAKE : ST_LP;
				ST_LP: begin
					if (irq_lvl)
						state_reg <= ST_RUN;
					else if (wake_dma)
						state_reg <= ST_DMAWAKE;
				end
				ST_DMAWAKE: begin
					if (irq_lvl)
						state_reg <= ST_RUN;
					else if (!wake_dma && dma_done_in)
						state_reg <= ST_ENT_MST;
				end
				ST_COMPUTE: begin
					if (!compute_req_in || (irq_lvl && compute_irq_exit_reg))
						state_reg <= ST_RUN;
					else if (wake_dma)
						state_reg <= ST_CPDMA;
				end
				ST_CPDMA: begin
					if (irq_lvl && compute_irq_exit_reg)
						state_reg <= ST_RUN;
					else if (!wake_dma && dma_done_in)
						state_reg <= ST_COMPUTE;
				end
				default: state_reg <= ST_POR;
			endcase
		end
	end
	// option byte captured once clocks run
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in)
			option_reg <= 8'h00;
		else if (state_reg == ST_CLKEN && cnt_reg == 16'h0000)
			option_reg <= nv_option_in;
	end
	// boot decision sampled when pin releases
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			take_nmi_reg  <= 1'b0;
			force_rom_reg <= 1'b0;
		end else if (state_reg == ST_PINWAIT && pin_high) begin
			take_nmi_reg  <= !boot_sync_reg[1] && option_reg[BRS_OPT_NMI]
				&& option_reg[BRS_OPT_BPIN];
			force_rom_reg <= !boot_sync_reg[1] && !option_reg[BRS_OPT_BPIN];
		end
	end
	// ======================================================================
	// outputs to clients
	wire in_reset = (state_reg == ST_POR) || (state_reg == ST_CLKEN)
		|| (state_reg == ST_FLASH) || (state_reg == ST_PINWAIT);
	wire stopped  = (state_reg == ST_ENT_PWR) || (state_reg == ST_LP);
	wire [1:0] lpb = {option_reg[BRS_OPT_LPB_HI], option_reg[BRS_OPT_LPB_LO]};
	always_comb begin
		reset_pin_out    = 1'b0;
		reset_pin_oe_out = (state_reg == ST_CLKEN) || (state_reg == ST_FLASH);
		flash_rst_n_out  = (state_reg != ST_POR) && (state_reg != ST_CLKEN);
		sys_rst_n_out    = !in_reset;
		flash_slow_clk_out = !option_reg[BRS_OPT_FAST];
		case (lpb)
			2'h0: core_clock_divider_out = BRS_DIV8;
			2'h1: core_clock_divider_out = BRS_DIV4;
			2'h2: core_clock_divider_out = BRS_DIV2;
			default: core_clock_divider_out = BRS_DIV1;
		endcase
		very_low_power_run_mode_out = !lpb[1];
		clk_ctl_out.clkgen_en     = (state_reg != ST_POR) &&
			!(stopped && lp_mode_reg == BRS_LP_STOP);
		clk_ctl_out.regulator_run = clk_ctl_out.clkgen_en;
		clk_ctl_out.sys_clk_en    = (state_reg != ST_POR) && !stopped;
		clk_ctl_out.flash_clk_en  = clk_ctl_out.sys_clk_en;
		clk_ctl_out.bus_clk_en    = (state_reg != ST_POR) &&
			!(stopped && lp_mode_reg != BRS_LP_PS2);
		clk_ctl_out.core_clk_en   = !in_reset && (state_reg == ST_RUN
			|| state_reg == ST_COMPUTE || state_reg == ST_CPDMA);
		clk_ctl_out.master_stop   = (state_reg == ST_ENT_MST) || (state_reg == ST_ENT_SLV)
			|| stopped || (state_reg == ST_COMPUTE);
		clk_ctl_out.slave_stop    = (state_reg == ST_ENT_SLV) || stopped
			|| (state_reg == ST_COMPUTE);
		clk_ctl_out.bus_slave_stop = clk_ctl_out.slave_stop &&
			!(stopped && lp_mode_reg == BRS_LP_PS2);
		boot_out.take_nmi  = take_nmi_reg;
		boot_out.force_rom = force_rom_reg;
		boot_out.boot_src  = option_reg[BRS_OPT_SRC_HI:BRS_OPT_SRC_LO];
		boot_out.sp_addr   = BRS_VEC_SP;
		boot_out.pc_addr   = take_nmi_reg ? BRS_VEC_NMI : BRS_VEC_PC;
		boot_out.lr_value  = BRS_LR_RST;
		stop_abort_out     = stop_abort_reg;
	end
	// ======================================================================
	// axi4-lite slave
	logic aw_got_reg, w_got_reg;
	logic [7:0]  aw_reg;
	logic [31:0] wd_reg;
	logic [3:0]  ws_reg;
	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
	wire wr_hit  = (aw_reg == BRS_OFS_CTRL) || (aw_reg == BRS_OFS_DMAWEN)
		|| (aw_reg == BRS_OFS_STATUS);
	// write channel capture and response
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_got_reg <= 1'b0;
			w_got_reg  <= 1'b0;
			aw_reg     <= 8'h00;
			wd_reg     <= 32'h0000_0000;
			ws_reg     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				aw_reg     <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				wd_reg    <= s_axi_wdata;
				ws_reg    <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_reg   <= 1'b0;
				w_got_reg    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	// control registers written by software
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lp_mode_reg          <= BRS_CTRL_RST[1:0];
			compute_irq_exit_reg <= BRS_CTRL_RST[2];
			dma_wake_en_reg      <= '0;
		end else if (wr_fire && ws_reg[0]) begin
			if (aw_reg == BRS_OFS_CTRL) begin
				lp_mode_reg          <= wd_reg[1:0];
				compute_irq_exit_reg <= wd_reg[2];
			end
			if (aw_reg == BRS_OFS_DMAWEN)
				dma_wake_en_reg <= wd_reg[DMA_CH-1:0];
		end
	end
	// stop abort flag, set beats clear
	wire abort_set = wake_dma && !irq_lvl && (state_reg == ST_ENT_MST || state_reg == ST_ENT_SLV);
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in)
			stop_abort_reg <= 1'b0;
		else if (abort_set)
			stop_abort_reg <= 1'b1;
		else if (wr_fire && ws_reg[0] && aw_reg == BRS_OFS_STATUS && wd_reg[16])
			stop_abort_reg <= 1'b0;
	end
	// read channel
	logic [31:0] rd_val;
	logic        rd_ok;
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		case (s_axi_araddr)
			BRS_OFS_OPTION: rd_val = {24'h000000, option_reg};
			BRS_OFS_CTRL:   rd_val = {29'h0, compute_irq_exit_reg, lp_mode_reg};
			BRS_OFS_STATUS: rd_val = {15'h0, stop_abort_reg, 4'h0, state_reg};
			BRS_OFS_DMAWEN: rd_val = 32'(dma_wake_en_reg);
			BRS_OFS_BOOT:   rd_val = {28'h0, boot_out.boot_src, force_rom_reg, take_nmi_reg};
			default:        rd_ok  = 1'b0;
		endcase
	end
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
	// ======================================================================
	// checks
	property p_por_hold;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg == ST_POR && !lvd_sync_reg[1]) |=> state_reg == ST_POR;
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("left por early");
	property p_pin_drive;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg == ST_FLASH) |-> (reset_pin_oe_out && !sys_rst_n_out && flash_rst_n_out);
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("flash phase wrong");
	property p_pin_low_hold;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg == ST_PINWAIT && !pin_high) |=> !sys_rst_n_out;
	endproperty
	a_pin_low_hold: assert property (p_pin_low_hold) else $error("released on low pin");
	property p_release;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg == ST_PINWAIT && pin_high) |=> (sys_rst_n_out && clk_ctl_out.core_clk_en);
	endproperty
	a_release: assert property (p_release) else $error("no release");
	property p_div;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(lpb == 2'h0) |-> (core_clock_divider_out == BRS_DIV8 && very_low_power_run_mode_out);
	endproperty
	a_div: assert property (p_div) else $error("divider wrong");
	property p_ps2;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg == ST_LP && lp_mode_reg == BRS_LP_PS2) |->
			(clk_ctl_out.bus_clk_en && !clk_ctl_out.sys_clk_en);
	endproperty
	a_ps2: assert property (p_ps2) else $error("level two clocks wrong");
	property p_ps1;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg == ST_LP && lp_cur) |->
			(!clk_ctl_out.bus_clk_en && clk_ctl_out.clkgen_en);
	endproperty
	a_ps1: assert property (p_ps1) else $error("level one clocks wrong");
	property p_dma_core;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg == ST_DMAWAKE) |-> (!clk_ctl_out.core_clk_en && clk_ctl_out.sys_clk_en
			&& !clk_ctl_out.master_stop);
	endproperty
	a_dma_core: assert property (p_dma_core) else $error("dma wake clocks wrong");
	property p_irq_exit;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(state_reg == ST_DMAWAKE && irq_lvl) |=> state_reg == ST_RUN;
	endproperty
	a_irq_exit: assert property (p_irq_exit) else $error("no irq exit");
	property p_abort;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		abort_set |=> (stop_abort_reg && state_reg == ST_DMAWAKE);
	endproperty
	a_abort: assert property (p_abort) else $error("abort missed");
endmodule

// [brs_pin_partner.sv]
// far side: reset pin with pull-up and boot config pin
// assumes the design drives the reset pin open drain
`timescale 1ns/1ns
module brs_pin_partner (
	input  wire logic drv_in,      // design pin drive value
	input  wire logic oe_in,       // design pin drive enable
	input  wire logic hold_low_in, // outside holds pin low
	input  wire logic cfg_in,      // boot config level
	output logic      pin_out,     // resolved reset pin
	output logic      cfg_pin_out  // boot config pin
);
	// open drain wire, pulled up when nobody drives
	assign pin_out = ((oe_in && !drv_in) || hold_low_in) ? 1'b0 : 1'b1;
	assign cfg_pin_out = cfg_in;
endmodule

// [tb_top.sv]
// self-checking bench for the boot and low-power sequencer
// assumes brs_pkg, brs_seq and brs_pin_partner are compiled first
`timescale 1ns/1ns
module tb_top import brs_pkg::*; ();
	localparam logic [3:0] DIVT [4] = '{BRS_DIV8, BRS_DIV4, BRS_DIV2, BRS_DIV1};
	logic clk_sys_in, rst_n_in, supply_good_in, lvd_safe_in, reset_pin_in, reset_pin_out;
	logic reset_pin_oe_out, boot_config_pin_in, flash_rst_n_out, sys_rst_n_out, stop_abort_out;
	logic very_low_power_run_mode_out, flash_slow_clk_out, async_irq_in, bus_sync_irq_in;
	logic dma_done_in, lp_request_in, compute_req_in, master_ack_in, slave_ack_in, hold, cfg;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  nv_option_in, s_axi_awaddr, s_axi_araddr, o;
	logic [31:0] s_axi_wdata, s_axi_rdata, rng;
	logic [3:0]  s_axi_wstrb, core_clock_divider_out, dma_req_in;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [34:0] q[$];
	logic [1:0]  wq[$];
	logic [34:0] e;
	brs_clk_s    clk_ctl_out;
	brs_boot_s   boot_out;
	int          fails, comparisons, cycles, i, m;
	// ======================================================================
	// design and far side
	brs_seq #(.DMA_CH(4), .FLASH_INIT(4)) i_dut (.clk_sys_in, .rst_n_in, .supply_good_in,
		.lvd_safe_in, .nv_option_in, .reset_pin_in, .reset_pin_out, .reset_pin_oe_out,
		.boot_config_pin_in, .flash_rst_n_out, .sys_rst_n_out, .core_clock_divider_out,
		.very_low_power_run_mode_out, .flash_slow_clk_out, .clk_ctl_out, .boot_out,
		.async_irq_in, .bus_sync_irq_in, .dma_req_in, .dma_done_in, .lp_request_in,
		.compute_req_in, .master_ack_in, .slave_ack_in, .stop_abort_out, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	brs_pin_partner i_pins (.drv_in(reset_pin_out), .oe_in(reset_pin_oe_out),
		.hold_low_in(hold), .cfg_in(cfg), .pin_out(reset_pin_in),
		.cfg_pin_out(boot_config_pin_in));
	// clock, acknowledges, timeout
	initial begin
		clk_sys_in = 0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		master_ack_in <= clk_ctl_out.master_stop;
		slave_ack_in <= clk_ctl_out.slave_stop;
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fails++;
			complete_run();
		end
	end
	// response monitor takes the oldest note
	always @(negedge clk_sys_in) begin
		if (s_axi_bvalid && s_axi_bready) check("bresp", s_axi_bresp, wq.pop_front());
		if (s_axi_rvalid && s_axi_rready) begin
			e = q.pop_front();
			check("rresp", s_axi_rresp, e[1:0]);
			if (e[34]) check("rdata", s_axi_rdata, e[33:2]);
		end
	end
	// ======================================================================
	// helpers
	function logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	function logic pick(int s);
		case (s)
			0: return reset_pin_oe_out;
			1: return flash_rst_n_out;
			2: return sys_rst_n_out;
			3: return clk_ctl_out.sys_clk_en;
			default: return clk_ctl_out.core_clk_en;
		endcase
	endfunction
	task check(input string n, input logic [99:0] s, input logic [99:0] x);
		comparisons++;
		if (s !== x) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	task wait_for(input int s, input logic v);
		int k;
		for (k = 0; k < 400; k++) begin
			@(negedge clk_sys_in);
			if (pick(s) === v) break;
		end
		check("wait", k < 400, 1'b1);
	endtask
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ta, tw, bv;
		wq.push_back(r);
		@(posedge clk_sys_in);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		for (int k = 0; k < 100; k++) begin
			@(negedge clk_sys_in);
			{ta, tw, bv} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
			@(posedge clk_sys_in);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			if (bv) break;
		end
		s_axi_bready <= 0;
	endtask
	task axi_rd(input logic [7:0] a, input logic c, input logic [31:0] d, input logic [1:0] r);
		logic ta, rv;
		q.push_back({c, d, r});
		@(posedge clk_sys_in);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		for (int k = 0; k < 100; k++) begin
			@(negedge clk_sys_in);
			{ta, rv} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
			@(posedge clk_sys_in);
			if (ta) s_axi_arvalid <= 0;
			if (rv) break;
		end
		s_axi_rready <= 0;
	endtask
	task boot(input logic [7:0] b, input logic p);
		logic nmi, rom;
		nmi = !p && b[2] && b[1];
		rom = !b[1] && !p;
		@(posedge clk_sys_in);
		{rst_n_in, supply_good_in, lvd_safe_in, nv_option_in, cfg, hold} <= {3'b000, b, p, 1'b1};
		repeat (5) @(posedge clk_sys_in);
		{rst_n_in, supply_good_in} <= 2'b11;
		repeat (6) @(negedge clk_sys_in);
		check("por", reset_pin_oe_out, 1'b0);
		@(posedge clk_sys_in);
		lvd_safe_in <= 1;
		wait_for(0, 1);
		check("hold", {flash_rst_n_out, sys_rst_n_out}, 2'b00);
		wait_for(1, 1);
		check("flash", {reset_pin_oe_out, sys_rst_n_out}, 2'b10);
		wait_for(0, 0);
		repeat (8) @(negedge clk_sys_in);
		check("pinlow", sys_rst_n_out, 1'b0);
		@(posedge clk_sys_in);
		hold <= 0;
		wait_for(2, 1);
		check("core", clk_ctl_out.core_clk_en, 1'b1);
		check("div", {core_clock_divider_out, very_low_power_run_mode_out, flash_slow_clk_out},
			{DIVT[{b[4], b[0]}], !b[4], !b[5]});
		check("boot", boot_out, {nmi, rom, b[7:6], BRS_VEC_SP, nmi ? BRS_VEC_NMI : BRS_VEC_PC,
			BRS_LR_RST});
		axi_rd(BRS_OFS_OPTION, 1, {24'h0, b}, 2'h0);
		axi_rd(BRS_OFS_BOOT, 1, {28'h0, b[7:6], rom, nmi}, 2'h0);
	endtask
	task complete_run();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ======================================================================
	// main sequence
	initial begin
		{rst_n_in, supply_good_in, lvd_safe_in, nv_option_in, async_irq_in, bus_sync_irq_in} = '0;
		{dma_req_in, dma_done_in, lp_request_in, compute_req_in, hold, cfg} = '0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, fails, comparisons, cycles} = '0;
		rng = 32'h0000_002A;
		for (i = 0; i < 4; i++) begin
			o = xs();
			{o[4], o[0]} = i[1:0];
			if (i == 2) o[1] = 0;
			if (i == 3) o[2:1] = 2'h3;
			boot(o, (i < 2) ? xs() : 1'b0);
		end
		axi_rd(8'hFC, 0, 32'h0, 2'h2);
		axi_wr(8'hFC, 32'h0, 2'h2);
		axi_wr(BRS_OFS_DMAWEN, 32'h1, 2'h0);
		for (m = 1; m < 4; m++) begin
			axi_wr(BRS_OFS_CTRL, m, 2'h0);
			@(posedge clk_sys_in);
			lp_request_in <= 1;
			@(posedge clk_sys_in);
			lp_request_in <= 0;
			wait_for(3, 0);
			check("lp", {clk_ctl_out.core_clk_en, clk_ctl_out.sys_clk_en, clk_ctl_out.bus_clk_en,
				clk_ctl_out.clkgen_en, clk_ctl_out.regulator_run},
				{2'b00, m == 2, m != 3, m != 3});
			@(posedge clk_sys_in);
			dma_req_in <= 4'h1;
			wait_for(3, 1);
			check("wake", {clk_ctl_out.core_clk_en, clk_ctl_out.master_stop, clk_ctl_out.slave_stop,
				clk_ctl_out.bus_clk_en, clk_ctl_out.clkgen_en}, 5'h03);
			@(posedge clk_sys_in);
			{dma_req_in, dma_done_in} <= {4'h0, 1'b1};
			wait_for(3, 0);
			check("reenter", {clk_ctl_out.master_stop, clk_ctl_out.clkgen_en},
				{1'b1, m != 3});
			@(posedge clk_sys_in);
			{dma_done_in, bus_sync_irq_in, async_irq_in} <= {1'b0, m == 2, m != 2};
			wait_for(4, 1);
			check("exit", clk_ctl_out.sys_clk_en, 1'b1);
			@(posedge clk_sys_in);
			{bus_sync_irq_in, async_irq_in} <= 2'b00;
		end
		// dma request already up while entry starts: entry aborts, flag set
		axi_wr(BRS_OFS_CTRL, 1, 2'h0);
		@(posedge clk_sys_in);
		{lp_request_in, dma_req_in} <= {1'b1, 4'h1};
		@(posedge clk_sys_in);
		lp_request_in <= 0;
		repeat (5) @(posedge clk_sys_in);
		{dma_req_in, dma_done_in} <= {4'h0, 1'b1};
		wait_for(3, 0);
		check("abort", stop_abort_out, 1'b1);
		@(posedge clk_sys_in);
		dma_done_in <= 0;
		axi_rd(BRS_OFS_STATUS, 1, {15'h0, 1'b1, 4'h0, ST_LP}, 2'h0);
		axi_wr(BRS_OFS_STATUS, 32'h0001_0000, 2'h0);
		axi_rd(BRS_OFS_STATUS, 1, {20'h0, ST_LP}, 2'h0);
		async_irq_in <= 1;
		wait_for(4, 1);
		// compute operation keeps the core clock, dma lifts the stops
		@(posedge clk_sys_in);
		{async_irq_in, compute_req_in} <= 2'b01;
		repeat (3) @(negedge clk_sys_in);
		check("cpo", {clk_ctl_out.core_clk_en, clk_ctl_out.master_stop}, 2'b11);
		@(posedge clk_sys_in);
		dma_req_in <= 4'h1;
		repeat (5) @(negedge clk_sys_in);
		check("cpdma", {clk_ctl_out.core_clk_en, clk_ctl_out.master_stop}, 2'b10);
		@(posedge clk_sys_in);
		{dma_req_in, dma_done_in, compute_req_in} <= {4'h0, 1'b1, 1'b0};
		repeat (6) @(posedge clk_sys_in);
		complete_run();
	end
endmodule
